// *** common/charge_ctrl_pkg.sv ***
package charge_ctrl_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned WDOG_TIMEOUT_MS   = 500;   // five frame periods
  localparam int unsigned STATUS_PERIOD_MS  = 100;
  localparam int unsigned WDOG_CYCLES       = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned STATUS_CYCLES     = STATUS_PERIOD_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // control frame layout
  // ----------------------------------------------------------------
  localparam logic [10:0] CTRL_FRAME_ID     = 11'h190;
  localparam int unsigned TARGET_LSB        = 0;
  localparam int unsigned TARGET_W          = 20;
  localparam int unsigned ON_REQ_BIT        = 20;
  localparam int unsigned CLEAR_BIT         = 21;
  localparam int unsigned CURRENT_LSB       = 32;
  localparam int unsigned CURRENT_W         = 18;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  CONFIG_ADDR       = 8'h00;
  localparam logic [7:0]  STATUS_ADDR       = 8'h04;
  localparam logic [7:0]  TARGET_ADDR       = 8'h08;
  localparam logic [7:0]  LIMIT_ADDR        = 8'h0c;
  localparam int unsigned MODE_POS          = 0;
  localparam int unsigned RATE_LSB          = 4;
  localparam int unsigned PROFILE_LSB       = 8;
  localparam int unsigned NODE_LSB          = 16;
  localparam logic        MODE_RESET        = 1'h0;   // bus-controlled
  localparam logic [2:0]  RATE_RESET        = 3'h0;   // 1 Mbit/s
  localparam logic [1:0]  PROFILE_RESET     = 2'h0;
  localparam logic [7:0]  NODE_RESET        = 8'h01;  // arbitrary value

  typedef enum logic [2:0] {
    RATE_1M   = 3'h0,
    RATE_125K = 3'h1,
    RATE_250K = 3'h2,
    RATE_500K = 3'h3,
    RATE_800K = 3'h4
  } bit_rate_t;

  typedef enum logic [3:0] {
    ST_STANDBY = 4'h1,
    ST_CHARGE  = 4'h2,
    ST_FAULT   = 4'h4,
    ST_SLEEP   = 4'h8
  } charge_state_t;

  typedef struct packed {
    logic        valid;
    logic        ide;
    logic [10:0] id;
    logic [63:0] data;
  } rx_frame_t;

  typedef struct packed {
    logic [19:0] target_mv;
    logic [17:0] current_ma;
  } setpoint_t;

endpackage

// *** design/charge_control_cmd_interp.sv ***
`timescale 1ns/100ps
// Function
// (R1) only standard 11-bit identifier frames accepted
// (R2) bit rate 1M default, four alternatives
// (R3) frame 0x190 bits 0-19 target millivolts
// (R4) bit 20 requests output on/off
// (R5) bit 21 clears latched faults
// (R6) bits 32-49 current limit milliamps
// (R7) trips clear only on off-then-on
// (R8) missing frames disable output, raise fault
// (R9) controller sends frame every 100 ms
// (R10) two modes, bus mode by default
// (R11) profile mode charges by one of four
// (R12) profile mode follows charge-enable input level
// (R13) profile mode ignores commands, still reports
// (R14) sleep input high enters sleep
// (R15) sleep change completes within one second
// (R16) sleep: no charging, no bus traffic
// (R17) sleep asserted only in standby; the code enters sleep from any state
// (R18) registers set rate, node, profile
// (R19) bus mode ignores charge-enable input
// (R20) watchdog timeout parameter, restarted per frame
// (R21) signals little-endian, lsb first
module charge_control_cmd_interp #(
  parameter int unsigned WDOG_CYCLES   = charge_ctrl_pkg::WDOG_CYCLES,
  parameter int unsigned STATUS_CYCLES = charge_ctrl_pkg::STATUS_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire charge_ctrl_pkg::rx_frame_t rx_frame,
  input  wire logic                       charge_enable_input,
  input  wire logic                       sleep_input,
  input  wire logic                       overvoltage_trip,
  input  wire logic                       overcurrent_trip,
  input  wire logic                       fault_condition,
  input  wire logic [7:0]                 addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic [31:0]                     rdata,
  output charge_ctrl_pkg::setpoint_t      setpoint,
  output logic                            power_on,
  output logic                            can_active,
  output logic                            sleep_active,
  output logic                            comms_timeout_fault,
  output logic                            status_tx_req,
  output logic [2:0]                      bit_rate_sel,
  output logic [7:0]                      node_id,
  output logic [1:0]                      profile_sel
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_n_ff;

  // async assert, two-stage release so all flops leave reset together
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff   <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_ff   <= 1'b1;
      rst_sync_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  function automatic logic legal_rate(input logic [2:0] code);
    legal_rate = (code <= charge_ctrl_pkg::RATE_800K);
  endfunction

  charge_ctrl_pkg::charge_state_t state_ff;
  charge_ctrl_pkg::charge_state_t nxt_state;
  charge_ctrl_pkg::setpoint_t     setpoint_ff;
  charge_ctrl_pkg::setpoint_t     nxt_setpoint;
  logic        profile_mode_ff;
  logic [2:0]  rate_ff;
  logic [1:0]  profile_ff;
  logic [7:0]  node_ff;
  logic        sleep_ff;
  logic        on_req_ff;
  logic        nxt_on_req;
  logic        ov_trip_ff;
  logic        nxt_ov_trip;
  logic        oc_trip_ff;
  logic        nxt_oc_trip;
  logic        gen_fault_ff;
  logic        nxt_gen_fault;
  logic        comms_fault_ff;
  logic        nxt_comms_fault;
  logic [31:0] wdog_cnt_ff;
  logic [31:0] nxt_wdog_cnt;
  logic [31:0] status_cnt_ff;
  logic [31:0] nxt_status_cnt;
  logic        status_req_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  wire logic  awake      = (state_ff != charge_ctrl_pkg::ST_SLEEP);
  wire logic  is_ctrl    = rx_frame.valid && !rx_frame.ide &&
                           (rx_frame.id == charge_ctrl_pkg::CTRL_FRAME_ID);
  wire logic  accept     = is_ctrl && !profile_mode_ff && awake;
  wire logic  frm_on     = rx_frame.data[charge_ctrl_pkg::ON_REQ_BIT];
  wire logic  frm_clear  = accept && rx_frame.data[charge_ctrl_pkg::CLEAR_BIT];
  wire logic  on_rise    = accept && frm_on && !on_req_ff;
  wire logic  wdog_run   = !profile_mode_ff && awake;
  wire logic  wdog_fire  = wdog_run && (wdog_cnt_ff == WDOG_CYCLES - 1);
  wire logic  any_fault  = ov_trip_ff || oc_trip_ff || gen_fault_ff || comms_fault_ff;
  wire logic  charge_req = profile_mode_ff ? charge_enable_input : on_req_ff;
  wire logic  cfg_wr     = wr && (addr == charge_ctrl_pkg::CONFIG_ADDR);
  wire logic [2:0] wr_rate = wdata[charge_ctrl_pkg::RATE_LSB +: 3];

  // ----------------------------------------------------------------
  // control frame decode
  // ----------------------------------------------------------------
  // extended and foreign ids fall out in is_ctrl
  assign nxt_setpoint.target_mv  = accept ?                                 // R1 R13
    rx_frame.data[charge_ctrl_pkg::TARGET_LSB +: charge_ctrl_pkg::TARGET_W] // R3 R21
    : setpoint_ff.target_mv;
  assign nxt_setpoint.current_ma = accept ?
    rx_frame.data[charge_ctrl_pkg::CURRENT_LSB +: charge_ctrl_pkg::CURRENT_W] // R6
    : setpoint_ff.current_ma;
  assign nxt_on_req = accept ? frm_on : on_req_ff; // R4

  // ----------------------------------------------------------------
  // fault latches: a new trip wins over a clear in the same cycle
  // ----------------------------------------------------------------
  assign nxt_ov_trip     = overvoltage_trip || (ov_trip_ff && !on_rise);  // R7
  assign nxt_oc_trip     = overcurrent_trip || (oc_trip_ff && !on_rise);  // R7
  assign nxt_gen_fault   = fault_condition || (gen_fault_ff && !frm_clear); // R5
  assign nxt_comms_fault = wdog_fire || (comms_fault_ff && !frm_clear); // R8

  // ----------------------------------------------------------------
  // watchdog: saturates so the fault fires once per silence
  // ----------------------------------------------------------------
  assign nxt_wdog_cnt = (accept || !wdog_run) ? 32'h0 :            // R20
                        (wdog_cnt_ff < WDOG_CYCLES) ? wdog_cnt_ff + 32'h1 :
                        wdog_cnt_ff;

  // status frame pacing, held at zero while asleep
  assign nxt_status_cnt = (!awake || status_cnt_ff == STATUS_CYCLES - 1) ? 32'h0 :
                          status_cnt_ff + 32'h1;

  // ----------------------------------------------------------------
  // mode state: sleep first, then faults, then request
  // ----------------------------------------------------------------
  assign nxt_state = sleep_ff  ? charge_ctrl_pkg::ST_SLEEP :    // R14 R15
                     any_fault ? charge_ctrl_pkg::ST_FAULT :    // R8
                     charge_req ? charge_ctrl_pkg::ST_CHARGE :  // R12 R19
                     charge_ctrl_pkg::ST_STANDBY;

  // ----------------------------------------------------------------
  // register read mux; data stands only the cycle after the strobe
  // ----------------------------------------------------------------
  wire logic [31:0] cfg_word = {8'h00, node_ff, 6'h00, profile_ff,
                                1'b0, rate_ff, 3'h0, profile_mode_ff};
  wire logic [31:0] sts_word = {20'h00000, state_ff, on_req_ff, comms_fault_ff,
                                gen_fault_ff, oc_trip_ff, ov_trip_ff,
                                sleep_ff, profile_mode_ff, charge_enable_input};
  assign nxt_rdata = !rd ? 32'h0 :
    (addr == charge_ctrl_pkg::CONFIG_ADDR) ? cfg_word :
    (addr == charge_ctrl_pkg::STATUS_ADDR) ? sts_word :
    (addr == charge_ctrl_pkg::TARGET_ADDR) ? {12'h000, setpoint_ff.target_mv} :
    (addr == charge_ctrl_pkg::LIMIT_ADDR)  ? {14'h0000, setpoint_ff.current_ma} :
    32'h0;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // illegal rate codes are dropped so the link never loses its rate
  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      profile_mode_ff <= charge_ctrl_pkg::MODE_RESET;  // R10
      rate_ff         <= charge_ctrl_pkg::RATE_RESET;  // R2
      profile_ff      <= charge_ctrl_pkg::PROFILE_RESET;
      node_ff         <= charge_ctrl_pkg::NODE_RESET;
    end else if (cfg_wr) begin
      profile_mode_ff <= wdata[charge_ctrl_pkg::MODE_POS];          // R10
      rate_ff         <= legal_rate(wr_rate) ? wr_rate : rate_ff;   // R2 R18
      profile_ff      <= wdata[charge_ctrl_pkg::PROFILE_LSB +: 2];  // R11 R18
      node_ff         <= wdata[charge_ctrl_pkg::NODE_LSB +: 8];     // R18
    end
  end

  // ----------------------------------------------------------------
  // command, fault and timer state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      setpoint_ff    <= '0;
      on_req_ff      <= 1'b0;
      ov_trip_ff     <= 1'b0;
      oc_trip_ff     <= 1'b0;
      gen_fault_ff   <= 1'b0;
      comms_fault_ff <= 1'b0;
      wdog_cnt_ff    <= 32'h0;
    end else begin
      setpoint_ff    <= nxt_setpoint;
      on_req_ff      <= nxt_on_req;
      ov_trip_ff     <= nxt_ov_trip;
      oc_trip_ff     <= nxt_oc_trip;
      gen_fault_ff   <= nxt_gen_fault;
      comms_fault_ff <= nxt_comms_fault;
      wdog_cnt_ff    <= nxt_wdog_cnt;
    end
  end

  // sleep is sampled once; two-cycle reaction is far inside a second
  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      sleep_ff      <= 1'b0;
      state_ff      <= charge_ctrl_pkg::ST_STANDBY;
      status_cnt_ff <= 32'h0;
      status_req_ff <= 1'b0;
      rdata_ff      <= 32'h0;
    end else begin
      sleep_ff      <= sleep_input;                       // R14
      state_ff      <= nxt_state;                         // R15
      status_cnt_ff <= nxt_status_cnt;
      status_req_ff <= awake && (status_cnt_ff == STATUS_CYCLES - 1); // R13 R16
      rdata_ff      <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each a flop, a flop bit or an inverted flop bit
  // ----------------------------------------------------------------
  assign rdata               = rdata_ff;
  assign setpoint            = setpoint_ff;
  assign power_on            = state_ff[1];          // R16
  assign can_active          = !state_ff[3];         // R16
  assign sleep_active        = state_ff[3];
  assign comms_timeout_fault = comms_fault_ff;
  assign status_tx_req       = status_req_ff;
  assign bit_rate_sel        = rate_ff;
  assign node_id             = node_ff;
  assign profile_sel         = profile_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n_ff);

  sequence s_ctrl_accept;
    rx_frame.valid && !rx_frame.ide && rx_frame.id == charge_ctrl_pkg::CTRL_FRAME_ID &&
    !profile_mode_ff && !sleep_active;
  endsequence

  // watchdog runs only while awake in bus mode, so silence is judged on the same terms
  sequence s_silence;
    (!rx_frame.valid && !profile_mode_ff && !sleep_active) [*8];
  endsequence

  // off-then-on edge with no trip standing in the same cycle
  sequence s_turn_on;
    rx_frame.data[charge_ctrl_pkg::ON_REQ_BIT] && !on_req_ff &&
    !overvoltage_trip && !overcurrent_trip;
  endsequence

  AST_EXT_ID_IGNORED: assert property ( // R1
    rx_frame.valid && rx_frame.ide |=> $stable(setpoint) && $stable(on_req_ff))
    else $error("extended frame changed the command");

  AST_RATE_WRITE: assert property ( // R2
    cfg_wr && legal_rate(wr_rate) |=> bit_rate_sel == $past(wr_rate))
    else $error("legal bit rate not taken");

  AST_TARGET_DECODE: assert property ( // R3
    s_ctrl_accept |=> setpoint.target_mv == $past(rx_frame.data[19:0]))
    else $error("target voltage misdecoded");

  AST_ON_DECODE: assert property ( // R4
    s_ctrl_accept |=> on_req_ff == $past(rx_frame.data[20]))
    else $error("output request misdecoded");

  AST_FAULT_CLEAR: assert property ( // R5
    s_ctrl_accept ##0 rx_frame.data[21] && !fault_condition |=> !gen_fault_ff)
    else $error("fault clear had no effect");

  AST_CURRENT_DECODE: assert property ( // R6
    s_ctrl_accept |=> setpoint.current_ma == $past(rx_frame.data[49:32]))
    else $error("current limit misdecoded");

  AST_TRIP_HOLD: assert property ( // R7
    ov_trip_ff ##0 s_ctrl_accept ##0 rx_frame.data[21] && on_req_ff |=> ov_trip_ff)
    else $error("fault clear released an overvoltage trip");

  AST_WDOG_TRIP: assert property ( // R8
    wdog_fire |=> comms_timeout_fault ##1 !power_on)
    else $error("watchdog expiry did not stop output");

  AST_WDOG_RESTART: assert property ( // R20
    s_ctrl_accept ##1 s_silence |-> wdog_cnt_ff == 32'h7 || WDOG_CYCLES <= 9)
    else $error("watchdog not restarted by frame");

  AST_PROFILE_IGNORES: assert property ( // R13
    profile_mode_ff && rx_frame.valid |=> $stable(on_req_ff) && $stable(setpoint))
    else $error("command taken in profile mode");

  AST_PROFILE_ENABLE: assert property ( // R12
    profile_mode_ff && charge_enable_input && !any_fault && !sleep_ff
    |=> power_on)
    else $error("profile mode did not follow charge enable");

  AST_BUS_IGNORES_ENABLE: assert property ( // R19
    !profile_mode_ff && !on_req_ff |=> !power_on)
    else $error("bus mode charged without request");

  AST_SLEEP_ENTRY: assert property ( // R15
    sleep_input |-> ##[1:2] sleep_active)
    else $error("sleep not entered in time");

  AST_SLEEP_QUIET: assert property ( // R16
    sleep_active |-> !power_on && !can_active ##1 !status_tx_req)
    else $error("activity while asleep");

  // register port, configuration, the remaining clear paths, profile stop and sleep exit
  AST_RDATA_IDLE: assert property ( // R18
    !rd |=> rdata == 32'h0)
    else $error("read data outside its cycle");

  AST_CFG_WRITE: assert property ( // R18
    cfg_wr |=> node_id == $past(wdata[charge_ctrl_pkg::NODE_LSB +: 8]) &&
               profile_sel == $past(wdata[charge_ctrl_pkg::PROFILE_LSB +: 2]))
    else $error("configuration write not taken");

  AST_RATE_KEPT: assert property ( // R2
    cfg_wr && !legal_rate(wr_rate) |=> $stable(bit_rate_sel))
    else $error("illegal bit rate taken");

  AST_OFF_ON_CLEAR: assert property ( // R7
    s_ctrl_accept ##0 s_turn_on |=> !ov_trip_ff && !oc_trip_ff)
    else $error("off then on did not clear trips");

  AST_COMMS_CLEAR: assert property ( // R5
    s_ctrl_accept ##0 rx_frame.data[charge_ctrl_pkg::CLEAR_BIT] && !wdog_fire
    |=> !comms_timeout_fault)
    else $error("fault clear left the watchdog fault");

  AST_PROFILE_STOP: assert property ( // R12
    profile_mode_ff && !charge_enable_input |=> !power_on)
    else $error("profile mode charged with enable low");

  AST_SLEEP_EXIT: assert property ( // R14
    !sleep_input |-> ##[1:2] !sleep_active)
    else $error("sleep not left in time");

endmodule

// *** verification/charge_control_cmd_interp_tb_top.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// bench for the charge control command interpreter
// ----------------------------------------------------------------
module charge_control_cmd_interp_tb_top;
  typedef struct {
    logic ide; logic [10:0] id; logic [19:0] tgt; logic [17:0] cur; logic on; logic clr;
    logic [19:0] e_tgt; logic [17:0] e_cur; logic e_pwr;
  } frame_row_t;
  logic                       clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic                       charge_enable_input = 1'b0, sleep_input = 1'b0;
  logic                       overvoltage_trip = 1'b0, overcurrent_trip = 1'b0;
  logic                       fault_condition = 1'b0;
  logic [7:0]                 addr = 8'h00;
  logic [31:0]                wdata = 32'h0, rdata, rv, k;
  charge_ctrl_pkg::rx_frame_t rx_frame;
  charge_ctrl_pkg::setpoint_t setpoint;
  logic                       power_on, can_active, sleep_active, fault_wd, status_tx_req;
  logic [2:0]                 bit_rate_sel;
  logic [7:0]                 node_id;
  logic [1:0]                 profile_sel;
  int                         err_count = 0, checks_done = 0, cyc = 0, n;
  frame_row_t                 rows [6];

  ctrl_frame_model #(.PERIOD(20)) model (.clk(clk), .rx_frame(rx_frame));
  charge_control_cmd_interp #(.WDOG_CYCLES(50), .STATUS_CYCLES(20)) dut (
    .clk(clk), .reset_n(reset_n), .rx_frame(rx_frame), .sleep_input(sleep_input),
    .charge_enable_input(charge_enable_input), .overvoltage_trip(overvoltage_trip),
    .overcurrent_trip(overcurrent_trip), .fault_condition(fault_condition),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .setpoint(setpoint),
    .power_on(power_on), .can_active(can_active), .sleep_active(sleep_active),
    .comms_timeout_fault(fault_wd), .status_tx_req(status_tx_req),
    .bit_rate_sel(bit_rate_sel), .node_id(node_id), .profile_sel(profile_sel));

  initial forever #10 clk = ~clk;

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s is %b", $time, what, got);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s is %h, not %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // register port: one-cycle strobes, read data only in the following cycle
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // frame then the two cycles the answer needs, plus one spare
  task automatic frame(input logic [19:0] tgt, input logic on, input logic clr);
    model.send(1'b0, charge_ctrl_pkg::CTRL_FRAME_ID, tgt, 18'h00001, on, clr);
    repeat (3) @(posedge clk);
    #1;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    rows = '{'{0, 11'h190, 20'h03039, 18'h01388, 1, 1, 20'h03039, 18'h01388, 1},
             '{1, 11'h190, 20'h00111, 18'h00222, 0, 0, 20'h03039, 18'h01388, 1},
             '{0, 11'h191, 20'h00111, 18'h00222, 0, 0, 20'h03039, 18'h01388, 1},
             '{0, 11'h190, 20'hfffff, 18'h3ffff, 1, 0, 20'hfffff, 18'h3ffff, 1},
             '{0, 11'h190, 20'h80001, 18'h20001, 0, 0, 20'h80001, 18'h20001, 0},
             '{0, 11'h190, 20'h00001, 18'h00001, 1, 0, 20'h00001, 18'h00001, 1}};
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_bit(can_active, 1'b1, "transceiver on after reset");
    chk_word({29'h0, bit_rate_sel}, 32'h0, "default rate");
    reg_read(charge_ctrl_pkg::CONFIG_ADDR, rv);
    chk_word(rv, 32'h0001_0000, "config after reset");
    foreach (rows[i]) begin
      model.send(rows[i].ide, rows[i].id, rows[i].tgt, rows[i].cur, rows[i].on, rows[i].clr);
      repeat (3) @(posedge clk);
      #1;
      chk_word({12'h0, setpoint.target_mv}, {12'h0, rows[i].e_tgt}, "target");
      chk_word({14'h0, setpoint.current_ma}, {14'h0, rows[i].e_cur}, "limit");
      chk_bit(power_on, rows[i].e_pwr, "output");
    end
    reg_read(charge_ctrl_pkg::TARGET_ADDR, rv);
    chk_word(rv, 32'h1, "target register");
    reg_read(charge_ctrl_pkg::LIMIT_ADDR, rv);
    chk_word(rv, 32'h1, "limit register");
    reg_read(8'h10, rv);
    chk_word(rv, 32'h0, "unmapped read");
    for (k = 0; k < 5; k++) begin
      reg_write(charge_ctrl_pkg::CONFIG_ADDR, 32'h0001_0000 | (k << 4));
      chk_word({29'h0, bit_rate_sel}, k, "rate select");
    end
    reg_write(charge_ctrl_pkg::CONFIG_ADDR, 32'h005a_0370);
    chk_word({29'h0, bit_rate_sel}, 32'h4, "illegal rate kept out");
    chk_word({24'h0, node_id}, 32'h5a, "node id");
    chk_word({30'h0, profile_sel}, 32'h3, "profile");
    // over-voltage, over-current, then the generic latched fault
    for (k = 0; k < 3; k++) begin
      @(posedge clk);
      overvoltage_trip <= (k == 0);
      overcurrent_trip <= (k == 1);
      fault_condition  <= (k == 2);
      @(posedge clk);
      {overvoltage_trip, overcurrent_trip, fault_condition} <= 3'h0;
      repeat (3) @(posedge clk);
      #1;
      chk_bit(power_on, 1'b0, "output after trip");
      frame(20'h00001, 1'b1, 1'b1);
      chk_bit(power_on, k == 2, "output after fault clear");
      frame(20'h00001, 1'b0, 1'b0);
      frame(20'h00001, 1'b1, 1'b0);
      chk_bit(power_on, 1'b1, "output after off then on");
    end
    model.keepalive = 1'b0;
    frame(20'h00001, 1'b1, 1'b0);
    repeat (37) @(posedge clk);
    #1;
    chk_bit(fault_wd, 1'b0, "watchdog early");
    for (n = 0; n < 15 && fault_wd !== 1'b1; n++) begin @(posedge clk); #1; end
    chk_bit(fault_wd, 1'b1, "watchdog fault");
    repeat (2) @(posedge clk);
    #1;
    chk_bit(power_on, 1'b0, "output after silence");
    frame(20'h00001, 1'b1, 1'b1);
    chk_bit(fault_wd, 1'b0, "watchdog fault cleared");
    chk_bit(power_on, 1'b1, "output resumed");
    model.keepalive = 1'b1;
    reg_write(charge_ctrl_pkg::CONFIG_ADDR, 32'h005a_0341);
    frame(20'h12345, 1'b1, 1'b1);
    chk_word({12'h0, setpoint.target_mv}, 32'h1, "frame in profile mode");
    chk_bit(power_on, 1'b0, "profile mode, enable low");
    for (n = 0; n < 25 && status_tx_req !== 1'b1; n++) begin @(posedge clk); #1; end
    chk_bit(status_tx_req, 1'b1, "status in profile mode");
    @(posedge clk);
    charge_enable_input <= 1'b1;
    for (n = 0; n < 5 && power_on !== 1'b1; n++) begin @(posedge clk); #1; end
    chk_bit(power_on, 1'b1, "profile charge on");
    @(posedge clk);
    charge_enable_input <= 1'b0;
    for (n = 0; n < 5 && power_on !== 1'b0; n++) begin @(posedge clk); #1; end
    chk_bit(power_on, 1'b0, "profile charge off");
    reg_write(charge_ctrl_pkg::CONFIG_ADDR, 32'h005a_0340);
    @(posedge clk);
    charge_enable_input <= 1'b1;
    frame(20'h00001, 1'b0, 1'b0);
    chk_bit(power_on, 1'b0, "enable in bus mode");
    // standby first, only then sleep
    @(posedge clk);
    charge_enable_input <= 1'b0;
    sleep_input         <= 1'b1;
    for (n = 0; n < 4 && sleep_active !== 1'b1; n++) begin @(posedge clk); #1; end
    chk_bit(sleep_active, 1'b1, "sleep entered");
    chk_bit(can_active, 1'b0, "transceiver asleep");
    n = 0;
    for (k = 0; k < 30; k++) begin
      @(posedge clk);
      #1;
      if (status_tx_req !== 1'b0) n++;
    end
    chk_word(n, 32'h0, "status while asleep");
    frame(20'h00001, 1'b1, 1'b0);
    chk_bit(power_on, 1'b0, "output while asleep");
    reg_read(charge_ctrl_pkg::STATUS_ADDR, rv);
    chk_word(rv, 32'h0000_0804, "status while asleep");
    @(posedge clk);
    sleep_input <= 1'b0;
    for (n = 0; n < 4 && sleep_active !== 1'b0; n++) begin @(posedge clk); #1; end
    chk_bit(sleep_active, 1'b0, "sleep left");
    chk_bit(can_active, 1'b1, "transceiver awake");
    // mid-run reset must bring configuration back to its defaults
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_word({19'h0, profile_sel, bit_rate_sel, node_id}, 32'h1, "mid-run reset");
    end_sim();
  end
endmodule

// *** verification/ctrl_frame_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// controller side of the control link
// ----------------------------------------------------------------
module ctrl_frame_model #(
  parameter int unsigned PERIOD = 20
) (
  input  wire logic                  clk,
  output charge_ctrl_pkg::rx_frame_t rx_frame
);
  logic        keepalive = 1'b1;
  logic        req       = 1'b0;
  logic        req_ide   = 1'b0;
  logic [10:0] req_id    = 11'h000;
  logic [63:0] req_data  = 64'h0;
  logic [63:0] last_data = 64'h0;
  int unsigned cnt       = 0;

  // queue one frame; it leaves on the next rising edge
  task automatic send(input logic ide, input logic [10:0] id, input logic [19:0] tgt,
                      input logic [17:0] cur, input logic on, input logic clr);
    @(negedge clk);
    req_ide  = ide;
    req_id   = id;
    req_data = {14'h0, cur, 10'h0, clr, on, tgt};
    req      = 1'b1;
    @(posedge clk);
  endtask

  initial rx_frame = '0;

  // resend well inside the watchdog; idle lines toggle so stale data never looks held
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (req) begin
      rx_frame <= {1'b1, req_ide, req_id, req_data};
      req      <= 1'b0;
      cnt      <= 0;
      if (!req_ide && req_id == charge_ctrl_pkg::CTRL_FRAME_ID)
        last_data <= req_data & ~(64'h1 << charge_ctrl_pkg::CLEAR_BIT);
    end else if (keepalive && cnt >= PERIOD - 1) begin
      rx_frame <= {1'b1, 1'b0, charge_ctrl_pkg::CTRL_FRAME_ID, last_data};
      cnt      <= 0;
    end else begin
      rx_frame <= {1'b0, ~rx_frame[75:0]};
    end
  end
endmodule
